// file: ctrl_port_defines.vh
// Constants shared by the control port: bus identifiers, register map and SPI word layout.
`ifndef CTRL_PORT_DEFINES_VH
`define CTRL_PORT_DEFINES_VH

// Two-wire bus identifiers, direction bit included, chosen by the address pin.
`define DEV_ID_SEL_LOW   8'h34
`define DEV_ID_SEL_HIGH  8'h36
`define DEV_ID_DIR_BIT   0

// Register map.
`define REG_PART_ID      8'h00
`define REG_SILICON_REV  8'h01
`define REG_VOL_UPD_A    8'h06
`define REG_VOL_UPD_B    8'h07
`define REG_RESET_VALUE  16'h0000
`define REV_FIELD_MSB    2

// SPI control word layout.
`define SPI_WORD_BITS    24
`define SPI_DIR_BIT      23
`define SPI_ADDR_MSB     22
`define SPI_ADDR_LSB     16
`define SPI_DATA_MSB     15

// Reset levels of the pin synchroniser: sclk, sda and chip select idle high.
`define PIN_SYNC_RESET   6'h07

`endif

// file: ctrl_port_slave.v
// Dual-mode serial control port slave: two-wire bus or write-only SPI, with register file.
//
// Summary of operation
// - Select pin low picks two-wire mode, high picks SPI, floating disables the port.
// - Register readback exists only in two-wire mode; SPI never drives data.
// - Two-wire data line is only pulled low, never driven high.
// - Bus identifier is 34h with address pin low, 36h with it high.
// - Identifier bit zero gives direction: one reads, zero writes.
// - Start is data falling with clock high; stop is data rising with clock high.
// - After a start, eight bits are shifted in MSB first as identifier byte.
// - A matching identifier is acknowledged by holding data low for one clock pulse.
// - Wrong identifier or direction gets no acknowledge; port idles until next start.
// - After identifier, register address and data, the port returns to idle.
// - A start or stop out of place aborts the transfer to idle.
// - Only single register writes and reads; register addresses are eight bits.
// - SPI word: zero direction bit, 7-bit address, 16 data bits, MSB first.
// - In SPI mode each rising serial clock with chip select low shifts one data bit in.
// - Chip-select rising commits the last 24 bits as one register write.
// - Volume update registers six and seven are unreachable over SPI.
// - Any write to address zero returns all registers to defaults.
// - Reading address zero returns the fixed part identification code.
// - Reading address one returns the silicon revision in bits two to zero.
// - Writes are ignored during power-on reset; afterwards registers hold defaults.
`timescale 1ns/1ps
`include "ctrl_port_defines.vh"

module ctrl_port_slave #(
    parameter        NREG     = 16,
    parameter [15:0] PART_ID  = 16'h5a5a,   // Arbitrary value.
    parameter [2:0]  REV_CODE = 3'h5        // Arbitrary value.
) (
    // Clock and reset.
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    // Power-on reset from the supply monitor, low while held in reset.
    input  wire        por_n_i,
    // Interface select pin, seen as a level and a separate floating indication.
    input  wire        interface_select_pin_i,
    input  wire        interface_select_float_i,
    // Serial pins.
    input  wire        sclk_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_o,
    input  wire        csn_i,
    // Register write notification to the rest of the device.
    output reg         reg_wr_o,
    output reg  [7:0]  reg_addr_o,
    output reg  [15:0] reg_data_o,
    output reg         soft_reset_o,
    // Port status.
    output wire        hw_mode_o
);

    // One-hot states of the two-wire engine.
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RX   = 5'h02;
    localparam [4:0] S_ACK  = 5'h04;
    localparam [4:0] S_TX   = 5'h08;
    localparam [4:0] S_MACK = 5'h10;

    reg  [1:0]  rst_sync_r;
    wire        rst_n;
    reg  [5:0]  sync1_r;
    reg  [5:0]  sync2_r;
    reg  [5:0]  sync3_r;
    reg  [5:0]  pin_r;
    reg  [5:0]  pin_d_r;
    wire [5:0]  pin_nxt;
    wire        scl_rise;
    wire        scl_fall;
    wire        sda_rise;
    wire        sda_fall;
    wire        cs_rise;
    wire        i2c_en;
    wire        spi_en;
    wire        por_ok;
    wire        start_ev;
    wire        stop_ev;
    reg  [4:0]  state_r;
    reg  [3:0]  bitcnt_r;
    reg  [1:0]  byte_idx_r;
    reg  [7:0]  shift_r;
    reg  [7:0]  tx_r;
    reg  [7:0]  addr_r;
    reg  [7:0]  data_hi_r;
    reg         rd_r;
    reg         rep_ok_r;
    reg         mack_r;
    reg         sda_oe_r;
    reg  [23:0] spi_sr_r;
    wire [7:0]  dev_id;
    wire        byte_done;
    wire        i2c_wr;
    wire        spi_wr;
    wire        spi_blocked;
    wire        wr_go;
    wire [7:0]  wr_addr;
    wire [15:0] wr_data;
    reg  [15:0] rd_val;
    reg  [15:0] regs_r [0:NREG-1];
    integer     k;

    // Reset release through two flops so every flop leaves reset on the same edge.
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Three-flop pin synchroniser; a level is accepted once stages two and three agree.
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= `PIN_SYNC_RESET;
            sync2_r <= `PIN_SYNC_RESET;
            sync3_r <= `PIN_SYNC_RESET;
            pin_r   <= `PIN_SYNC_RESET;
            pin_d_r <= `PIN_SYNC_RESET;
        end else begin
            sync1_r <= {por_n_i, interface_select_float_i, interface_select_pin_i, csn_i, sda_i, sclk_i};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_r   <= pin_nxt;
            pin_d_r <= pin_r;
        end
    end
    // Bitwise hold-unless-agreed; this also rejects glitches shorter than a clock.
    assign pin_nxt = (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));

    // Edges of the filtered pins.
    assign scl_rise = pin_r[0] & ~pin_d_r[0];
    assign scl_fall = ~pin_r[0] & pin_d_r[0];
    assign sda_rise = pin_r[1] & ~pin_d_r[1];
    assign sda_fall = ~pin_r[1] & pin_d_r[1];
    assign cs_rise  = pin_r[2] & ~pin_d_r[2];

    // Mode decode from the select pin.
    assign hw_mode_o = pin_r[4];
    assign i2c_en    = ~pin_r[4] & ~pin_r[3];
    assign spi_en    = ~pin_r[4] & pin_r[3];
    assign por_ok    = pin_r[5];

    // Bus conditions; the clock must be high both before and after the data edge.
    assign start_ev = i2c_en & sda_fall & pin_r[0] & pin_d_r[0];
    assign stop_ev  = i2c_en & sda_rise & pin_r[0] & pin_d_r[0];

    // Own identifier follows the address pin.
    assign dev_id    = pin_r[2] ? `DEV_ID_SEL_HIGH : `DEV_ID_SEL_LOW;
    assign byte_done = (state_r == S_RX) & scl_fall & (bitcnt_r == 4'h8);

    // The fourth byte of a write transaction commits the register.
    assign i2c_wr = i2c_en & byte_done & (byte_idx_r == 2'h3);

    // Readback value, addressed by the captured register address.
    always @* begin
        rd_val = 16'h0000;
        if (addr_r == `REG_PART_ID) begin
            rd_val = PART_ID;
        end else if (addr_r == `REG_SILICON_REV) begin
            rd_val = {13'h0000, REV_CODE};
        end else if (addr_r < NREG) begin
            rd_val = regs_r[addr_r[3:0]];
        end
    end

    // Two-wire slave engine.
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= S_IDLE;
            bitcnt_r   <= 4'h0;
            byte_idx_r <= 2'h0;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            addr_r     <= 8'h00;
            data_hi_r  <= 8'h00;
            rd_r       <= 1'b0;
            rep_ok_r   <= 1'b0;
            mack_r     <= 1'b0;
            sda_oe_r   <= 1'b0;
        end else if (!i2c_en) begin
            // SPI and hardware modes keep the data pin released.
            state_r  <= S_IDLE;
            sda_oe_r <= 1'b0;
        end else if (stop_ev) begin
            state_r  <= S_IDLE;
            sda_oe_r <= 1'b0;
        end else if (start_ev) begin
            bitcnt_r   <= 4'h0;
            byte_idx_r <= 2'h0;
            sda_oe_r   <= 1'b0;
            if (state_r == S_IDLE) begin
                state_r  <= S_RX;
                rep_ok_r <= 1'b0;
            end else if ((state_r == S_RX) && (byte_idx_r == 2'h2) && (bitcnt_r <= 4'h1)) begin
                // Repeated start right after the register address opens a read.
                state_r <= S_RX;
            end else begin
                state_r <= S_IDLE;
            end
        end else begin
            case (state_r)
                S_RX: begin
                    if (scl_rise) begin
                        shift_r  <= {shift_r[6:0], pin_r[1]};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (byte_done) begin
                        bitcnt_r <= 4'h0;
                        case (byte_idx_r)
                            2'h0: begin
                                // Reads are only valid once an address has been set.
                                if ((shift_r[7:1] == dev_id[7:1]) &&
                                    (!shift_r[`DEV_ID_DIR_BIT] || rep_ok_r)) begin
                                    rd_r     <= shift_r[`DEV_ID_DIR_BIT];
                                    state_r  <= S_ACK;
                                    sda_oe_r <= 1'b1;
                                end else begin
                                    state_r <= S_IDLE;
                                end
                            end
                            2'h1: begin
                                addr_r   <= shift_r;
                                rep_ok_r <= 1'b1;
                                state_r  <= S_ACK;
                                sda_oe_r <= 1'b1;
                            end
                            2'h2: begin
                                data_hi_r <= shift_r;
                                state_r   <= S_ACK;
                                sda_oe_r  <= 1'b1;
                            end
                            default: begin
                                state_r  <= S_ACK;
                                sda_oe_r <= 1'b1;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        if (rd_r) begin
                            // First data bit goes out on the same fall that ends the acknowledge.
                            tx_r       <= rd_val[15:8];
                            sda_oe_r   <= ~rd_val[15];
                            byte_idx_r <= 2'h2;
                            state_r    <= S_TX;
                        end else if (byte_idx_r == 2'h3) begin
                            sda_oe_r <= 1'b0;
                            state_r  <= S_IDLE;
                        end else begin
                            sda_oe_r   <= 1'b0;
                            byte_idx_r <= byte_idx_r + 2'h1;
                            state_r    <= S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt_r == 4'h8) begin
                            bitcnt_r <= 4'h0;
                            sda_oe_r <= 1'b0;
                            state_r  <= S_MACK;
                        end else begin
                            tx_r     <= {tx_r[6:0], 1'b0};
                            sda_oe_r <= ~tx_r[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        mack_r <= ~pin_r[1];
                    end else if (scl_fall) begin
                        if (mack_r && (byte_idx_r == 2'h2)) begin
                            tx_r       <= rd_val[7:0];
                            sda_oe_r   <= ~rd_val[7];
                            byte_idx_r <= 2'h3;
                            state_r    <= S_TX;
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe_r <= 1'b0;
                    state_r  <= S_IDLE;
                end
            endcase
        end
    end

    // Open-drain drive: the pin is only ever pulled low.
    assign sda_o    = 1'b0;
    assign sda_oe_o = sda_oe_r;

    // SPI shift register; chip select low frames the word.
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            spi_sr_r <= 24'h000000;
        end else if (spi_en && !pin_r[2] && scl_rise) begin
            spi_sr_r <= {spi_sr_r[22:0], pin_r[1]};
        end
    end

    // Commit on chip-select rise; reads and the volume update pair are refused.
    assign spi_blocked = (spi_sr_r[`SPI_DIR_BIT] != 1'b0) ||
                         ({1'b0, spi_sr_r[`SPI_ADDR_MSB:`SPI_ADDR_LSB]} == `REG_VOL_UPD_A) ||
                         ({1'b0, spi_sr_r[`SPI_ADDR_MSB:`SPI_ADDR_LSB]} == `REG_VOL_UPD_B);
    assign spi_wr  = spi_en & cs_rise & ~spi_blocked;

    // One write path for both protocols; a power-on reset swallows it.
    assign wr_go   = por_ok & (i2c_wr | spi_wr);
    assign wr_addr = i2c_wr ? addr_r : {1'b0, spi_sr_r[`SPI_ADDR_MSB:`SPI_ADDR_LSB]};
    assign wr_data = i2c_wr ? {data_hi_r, shift_r} : spi_sr_r[`SPI_DATA_MSB:0];

    // Register file; power-on reset and writes to address zero restore defaults.
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (k = 0; k < NREG; k = k + 1) begin
                regs_r[k] <= `REG_RESET_VALUE;
            end
        end else if (!por_ok) begin
            for (k = 0; k < NREG; k = k + 1) begin
                regs_r[k] <= `REG_RESET_VALUE;
            end
        end else if (wr_go) begin
            if (wr_addr == `REG_PART_ID) begin
                for (k = 0; k < NREG; k = k + 1) begin
                    regs_r[k] <= `REG_RESET_VALUE;
                end
            end else if ((wr_addr > `REG_SILICON_REV) && (wr_addr < NREG)) begin
                regs_r[wr_addr[3:0]] <= wr_data;
            end
        end
    end

    // Registered write notification; the revision register is read-only.
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr_o     <= 1'b0;
            reg_addr_o   <= 8'h00;
            reg_data_o   <= 16'h0000;
            soft_reset_o <= 1'b0;
        end else begin
            reg_wr_o     <= wr_go && (wr_addr != `REG_PART_ID) && (wr_addr != `REG_SILICON_REV);
            soft_reset_o <= (wr_go && (wr_addr == `REG_PART_ID)) || !por_ok;
            if (wr_go) begin
                reg_addr_o <= wr_addr;
                reg_data_o <= wr_data;
            end
        end
    end

endmodule // ctrl_port_slave

// file: ctrl_port_monitor.sv
// Port-level assertions for the dual-mode control port slave.
`timescale 1ns/1ps
module ctrl_port_monitor (
    // Clock and reset.
    input wire       sys_clk_i,
    input wire       rstn_i,
    // Mode and pin inputs.
    input wire       por_n_i,
    input wire       interface_select_pin_i,
    input wire       interface_select_float_i,
    input wire       sclk_i,
    input wire       csn_i,
    // Outputs under watch.
    input wire       sda_o,
    input wire       sda_oe_o,
    input wire       reg_wr_o,
    input wire [7:0] reg_addr_o,
    input wire       soft_reset_o,
    input wire       hw_mode_o
);
    // Pins take about four edges to be seen inside, so the mode checks wait eight samples.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_OPEN_DRAIN: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("data line driven high");
    AST_SPI_SILENT: assert property (interface_select_pin_i [*8] |-> !sda_oe_o)
        else $error("data line pulled in SPI mode");
    AST_HW_QUIET: assert property (interface_select_float_i [*8] |-> hw_mode_o && !sda_oe_o && !reg_wr_o)
        else $error("serial port active in hardware mode");
    AST_POR_BLOCK: assert property (!por_n_i [*8] |-> soft_reset_o && !reg_wr_o)
        else $error("write taken during power-on reset");
    AST_SPI_NO_VOL: assert property (reg_wr_o && interface_select_pin_i |-> reg_addr_o != 8'h06 && reg_addr_o != 8'h07)
        else $error("volume update register written over SPI");
    AST_WR_PULSE: assert property (reg_wr_o |-> (reg_addr_o >= 8'h02) ##1 !reg_wr_o)
        else $error("bad write pulse");
    AST_SPI_COMMIT: assert property ($rose(reg_wr_o) && interface_select_pin_i |-> csn_i && !$past(csn_i, 10))
        else $error("SPI write without chip-select rise");
    AST_ACK_AFTER_FALL: assert property ($rose(sda_oe_o) |-> !$past(sclk_i, 3))
        else $error("data pull began outside clock low phase");
    AST_STEADY_HIGH: assert property (sclk_i && $past(sclk_i) && !interface_select_pin_i |-> $stable(sda_oe_o))
        else $error("data pull changed while clock high");
    AST_SOFT_RESET: assert property ($rose(soft_reset_o) && por_n_i |-> ##[0:2] reg_addr_o == 8'h00)
        else $error("soft reset without write to address zero");
endmodule // ctrl_port_monitor

// Attach the checker to every slave instance.
bind ctrl_port_slave ctrl_port_monitor ctrl_port_monitor_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .por_n_i(por_n_i), .sclk_i(sclk_i), .csn_i(csn_i),
    .interface_select_pin_i(interface_select_pin_i), .interface_select_float_i(interface_select_float_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
    .soft_reset_o(soft_reset_o), .hw_mode_o(hw_mode_o));

// file: host_master_model.sv
// Behavioural host controller for the two-wire and SPI control pins.
`timescale 1ns/1ps
module host_master_model (
    // Mode and slave drive.
    input  wire spi_mode_i,
    input  wire sda_oe_i,
    // Pins towards the slave.
    output reg  sclk_o,
    output wire sda_o,
    output reg  csn_o
);
    localparam real H = 62.5;
    localparam real Q = 31.25;
    reg m_low;
    reg spi_sda;

    // Pulled-up wire, low if either side pulls; in SPI mode the data is ours alone.
    assign sda_o = spi_mode_i ? spi_sda : ~(m_low | sda_oe_i);
    initial begin
        sclk_o = 1'b1;
        csn_o = 1'b0;
        m_low = 1'b0;
        spi_sda = 1'b1;
    end
    // Park the pins; the SPI clock rests low so no stray edge reaches the shifter.
    task automatic park(input logic spi, input logic cs);
        #3 csn_o = cs;
        sclk_o = ~spi;
        m_low = 1'b0;
        spi_sda = 1'b1;
    endtask
    // One two-wire bit: data moves only while the clock is low.
    task automatic bit_io(input logic v, output logic s);
        #Q m_low = ~v;
        #Q sclk_o = 1'b1;
        #Q s = sda_o;
        #Q sclk_o = 1'b0;
    endtask
    // A long low phase first, so the slave's release is never taken for a stop.
    task automatic i2c_start;
        if (!sclk_o) begin
            #Q m_low = 1'b0;
            #H sclk_o = 1'b1;
        end
        #H m_low = 1'b1;
        #H sclk_o = 1'b0;
    endtask
    task automatic i2c_stop;
        #Q m_low = 1'b1;
        #Q sclk_o = 1'b1;
        #H m_low = 1'b0;
        #H;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask
    // Identifier, register address and two data bytes, high byte first.
    task automatic i2c_write(input logic [7:0] id, input logic [7:0] ra, input logic [15:0] d, output logic [3:0] a);
        #3 i2c_start;
        put_byte(id, a[3]);
        put_byte(ra, a[2]);
        put_byte(d[15:8], a[1]);
        put_byte(d[7:0], a[0]);
        i2c_stop;
    endtask
    task automatic i2c_read(input logic [7:0] id, input logic [7:0] ra, output logic [15:0] d, output logic [2:0] a);
        #3 i2c_start;
        put_byte(id, a[2]);
        put_byte(ra, a[1]);
        i2c_start;
        put_byte(id | 8'h01, a[0]);
        get_byte(1'b0, d[15:8]);
        get_byte(1'b1, d[7:0]);
        i2c_stop;
    endtask
    // Stray start inside the register-address byte, then the identifier again; a returns its acknowledge.
    task automatic i2c_abort(input logic [7:0] id, output logic a);
        logic s;
        #3 i2c_start;
        put_byte(id, a);
        repeat (4) bit_io(1'b0, s);
        i2c_start;
        put_byte(id, a);
        repeat (4) bit_io(1'b0, s);
        i2c_stop;
    endtask
    task automatic spi_word(input logic [23:0] w);
        #3 csn_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            #Q spi_sda = w[i];
            #Q sclk_o = 1'b1;
            #H sclk_o = 1'b0;
        end
        #H csn_o = 1'b1;
        #Q spi_sda = ~w[0];
    endtask
endmodule // host_master_model

// file: testbench.sv
// Self-checking testbench for the dual-mode control port slave.
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] PART_ID  = 16'h3c96; // Arbitrary value.
    localparam logic [2:0]  REV_CODE = 3'h2;     // Arbitrary value.
    logic        sys_clk_i, rstn_i, por_n_i, sel_r, float_r, sr_prev;
    wire         sclk, sda, csn, sda_o, sda_oe, reg_wr, soft_rst, hw_mode;
    wire [7:0]   reg_addr;
    wire [15:0]  reg_data;
    int          mismatches = 0, total_checks = 0, wr_cnt = 0, sr_cnt = 0;
    logic [3:0]  ak;
    logic [2:0]  rk;
    logic [15:0] rd;

    ctrl_port_slave #(.PART_ID(PART_ID), .REV_CODE(REV_CODE)) ctrl_port_slave_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .por_n_i(por_n_i), .interface_select_pin_i(sel_r),
        .interface_select_float_i(float_r), .sclk_i(sclk), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .csn_i(csn), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_data_o(reg_data),
        .soft_reset_o(soft_rst), .hw_mode_o(hw_mode));
    host_master_model host_master_model_i (
        .spi_mode_i(sel_r), .sda_oe_i(sda_oe), .sclk_o(sclk), .sda_o(sda), .csn_o(csn));

    // 100 MHz system clock.
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // Count write pulses and soft-reset rising edges; write pulses last a single cycle.
    always @(posedge sys_clk_i) begin
        sr_prev <= soft_rst;
        if (reg_wr === 1'b1) wr_cnt <= wr_cnt + 1;
        if (soft_rst === 1'b1 && sr_prev === 1'b0) sr_cnt <= sr_cnt + 1;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Leaves time for pin filtering and the registered outputs to land.
    task automatic settle;
        repeat (12) @(posedge sys_clk_i);
    endtask
    task automatic pins(input logic sel, input logic fl, input logic por);
        @(posedge sys_clk_i);
        sel_r <= sel;
        float_r <= fl;
        por_n_i <= por;
        settle;
    endtask
    task automatic wr_chk(input logic [7:0] id, input logic [7:0] ra, input logic [15:0] d,
                          input logic [3:0] eak, input logic ewr);
        int n;
        n = wr_cnt;
        host_master_model_i.i2c_write(id, ra, d, ak);
        settle;
        chk({12'h0, ak}, {12'h0, eak}, "acks");
        chk(16'(wr_cnt - n), {15'h0, ewr}, "write count");
        if (ewr) begin
            chk({8'h00, reg_addr}, {8'h00, ra}, "address");
            chk(reg_data, d, "data");
        end
    endtask
    task automatic rd_chk(input logic [7:0] id, input logic [7:0] ra, input logic [15:0] exp);
        host_master_model_i.i2c_read(id, ra, rd, rk);
        settle;
        chk({13'h0, rk}, 16'h0007, "read acks");
        chk(rd, exp, "read data");
    endtask
    task automatic spi_chk(input logic [23:0] w, input logic ewr);
        int n;
        n = wr_cnt;
        host_master_model_i.spi_word(w);
        settle;
        chk(16'(wr_cnt - n), {15'h0, ewr}, "spi write count");
        if (ewr) begin
            chk({8'h00, reg_addr}, {9'h0, w[22:16]}, "spi address");
            chk(reg_data, w[15:0], "spi data");
        end
    endtask
    task automatic t_ident;
        rd_chk(8'h34, 8'h00, PART_ID);
        rd_chk(8'h34, 8'h01, {13'h0, REV_CODE});
        rd_chk(8'h34, 8'h05, 16'h0000);
        $display("test ident done");
    endtask
    task automatic t_i2c;
        wr_chk(8'h34, 8'h05, 16'ha5c3, 4'hf, 1'b1);
        rd_chk(8'h34, 8'h05, 16'ha5c3);
        host_master_model_i.i2c_abort(8'h34, ak[0]);
        settle;
        chk({15'h0, ak[0]}, 16'h0000, "ack after stray start");
        chk(reg_data, 16'ha5c3, "aborted write");
        wr_chk(8'h34, 8'h09, 16'h1111, 4'hf, 1'b1);
        wr_chk(8'h34, 8'h06, 16'h0606, 4'hf, 1'b1);
        $display("test two-wire done");
    endtask
    task automatic t_addr_pin;
        host_master_model_i.park(1'b0, 1'b1);
        settle;
        wr_chk(8'h34, 8'h08, 16'h0f0f, 4'h0, 1'b0);
        wr_chk(8'h37, 8'h08, 16'h0f0f, 4'h0, 1'b0);
        wr_chk(8'h36, 8'h08, 16'h0f0f, 4'hf, 1'b1);
        rd_chk(8'h36, 8'h08, 16'h0f0f);
        host_master_model_i.park(1'b0, 1'b0);
        settle;
        $display("test address pin done");
    endtask
    task automatic t_spi;
        int n;
        host_master_model_i.park(1'b1, 1'b1);
        pins(1'b1, 1'b0, 1'b1);
        spi_chk({1'b0, 7'h04, 16'h1234}, 1'b1);
        spi_chk({1'b1, 7'h05, 16'hffff}, 1'b0);
        spi_chk({1'b0, 7'h06, 16'h00ff}, 1'b0);
        spi_chk({1'b0, 7'h07, 16'h00ff}, 1'b0);
        n = sr_cnt;
        spi_chk({1'b0, 7'h00, 16'hbeef}, 1'b0);
        chk(16'(sr_cnt - n), 16'h0001, "soft reset");
        host_master_model_i.park(1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b1);
        rd_chk(8'h34, 8'h05, 16'h0000);
        rd_chk(8'h34, 8'h09, 16'h0000);
        $display("test spi done");
    endtask
    task automatic t_power;
        wr_chk(8'h34, 8'h0a, 16'h5555, 4'hf, 1'b1);
        pins(1'b0, 1'b0, 1'b0);
        wr_chk(8'h34, 8'h0b, 16'h7777, 4'hf, 1'b0);
        pins(1'b0, 1'b0, 1'b1);
        rd_chk(8'h34, 8'h0a, 16'h0000);
        rd_chk(8'h34, 8'h0b, 16'h0000);
        pins(1'b0, 1'b1, 1'b1);
        wr_chk(8'h34, 8'h0b, 16'h7777, 4'h0, 1'b0);
        chk({15'h0, hw_mode}, 16'h0001, "hardware mode");
        pins(1'b0, 1'b0, 1'b1);
        $display("test power and mode done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        rstn_i = 1'b0;
        por_n_i = 1'b1;
        sel_r = 1'b0;
        float_r = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        settle;
        t_ident;
        t_i2c;
        t_addr_pin;
        t_spi;
        t_power;
        print_verdict;
    end
    // Watchdog at about three times the roughly 120 microseconds the tests need.
    initial begin
        #400_000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict;
    end
endmodule // testbench
